// *** bench/fwc_cache_sva.sv ***
// assertion checker watching the four-way cache ports
`timescale 1ns/10ps
module fwc_cache_sva #(
	parameter int WAYS = 4,
	parameter int ENTRIES = 128
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic mrstn,
	input wire logic cpuReq,
	input wire logic cpuWr,
	input wire logic [31:0] cpuAddr,
	input wire logic [31:0] cpuWdata,
	input wire logic cpuAck,
	input wire logic [31:0] cpuRdata,
	input wire logic memReq,
	input wire logic memWr,
	input wire logic [31:0] memAddr,
	input wire logic [31:0] memWdata,
	input wire logic memAck,
	input wire logic [31:0] memRdata,
	input wire logic [31:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdata
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn || !mrstn);
	logic dirDone_q; // last cycle finished an external word for the cpu address
	// helper kept as a register because $past takes a plain signal only
	always_ff @(posedge mclk) begin
		dirDone_q <= memReq && memAck && (memAddr == cpuAddr);
	end
	// a fresh cpu request
	sequence sTake;
		$rose(cpuReq);
	endsequence
	// lookup takes two cycles, then the answer comes in bounded time
	sequence sAnswer;
		!cpuAck ##1 !cpuAck ##[1:1000] cpuAck;
	endsequence
	a_req_answered: assert property (sTake |-> sAnswer)
		else $error("cpu request answered too early or never");
	a_ack_pulse: assert property (cpuAck |=> !cpuAck)
		else $error("cpu acknowledge longer than one cycle");
	a_mem_hold: assert property (memReq && !memAck |=> memReq && $stable(memAddr)
		&& $stable(memWr) && $stable(memWdata))
		else $error("external request changed before acknowledge");
	a_mem_gap: assert property (memReq && memAck |=> !memReq)
		else $error("external request not dropped after acknowledge");
	a_reg_idle: assert property (!regRd |=> regRdata == 32'h0)
		else $error("register read data outside the read answer");
	a_reg_unmapped: assert property (regRd && regAddr != fwc_pkg::CTRL_OFFSET |=>
		regRdata == 32'h0)
		else $error("unmapped register read not zero");
	a_reg_upper: assert property (regRd |=> regRdata[31:3] == 29'h0)
		else $error("unused control bits read nonzero");
	a_direct_access: assert property (cpuAck && cpuAddr[31:29] == 3'h5 |-> dirDone_q)
		else $error("uncached access answered without external word");
	a_reset_quiet: assert property (disable iff (1'b0) (!rstn || !mrstn) |=>
		!cpuAck && !memReq && regRdata == 32'h0)
		else $error("outputs active after reset");
endmodule : fwc_cache_sva

bind fwc_cache fwc_cache_sva #(.WAYS(WAYS), .ENTRIES(ENTRIES)) i_fwc_cache_sva (
	.mclk(mclk), .rstn(rstn), .mrstn(mrstn), .cpuReq(cpuReq), .cpuWr(cpuWr),
	.cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuAck(cpuAck), .cpuRdata(cpuRdata),
	.memReq(memReq), .memWr(memWr), .memAddr(memAddr), .memWdata(memWdata),
	.memAck(memAck), .memRdata(memRdata), .regAddr(regAddr), .regWdata(regWdata),
	.regWr(regWr), .regRd(regRd), .regRdata(regRdata));

// *** bench/fwc_mem_model.sv ***
// behavioural external memory bus controller for the cache
`timescale 1ns/10ps
module fwc_mem_model (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic slow,
	input wire logic memReq,
	input wire logic memWr,
	input wire logic [31:0] memAddr,
	input wire logic [31:0] memWdata,
	output logic memAck,
	output logic [31:0] memRdata,
	output logic [31:0] lastAddr,
	output int nRd,
	output int nWr
);
	logic [31:0] mem [logic [31:0]]; // sparse store, shadow bits ignored
	logic [31:0] a;
	int waitCnt;
	// answer each word after zero or three wait cycles
	always @(posedge mclk) begin
		a = memAddr & 32'h1fffffff;
		memAck <= 1'b0;
		memRdata <= ~memRdata; // read bus never holds stale data
		if (!rstn) begin
			waitCnt <= 0;
			nRd <= 0;
			nWr <= 0;
			memRdata <= 32'h0;
			lastAddr <= 32'h0;
		end else if (memReq && !memAck) begin
			if (waitCnt < (slow ? 3 : 0)) begin
				waitCnt <= waitCnt + 1;
			end else begin
				waitCnt <= 0;
				memAck <= 1'b1;
				lastAddr <= memAddr;
				if (memWr) begin
					mem[a] = memWdata;
					nWr <= nWr + 1;
				end else begin
					memRdata <= mem.exists(a) ? mem[a] : a ^ 32'h3c3c3c3c;
					nRd <= nRd + 1;
				end
			end
		end
	end
endmodule : fwc_mem_model

// *** bench/test_fwc_cache.sv ***
// self-checking bench for the four-way cache
`timescale 1ns/10ps
module test_fwc_cache;
	localparam logic [31:0] CR = fwc_pkg::CTRL_OFFSET;
	localparam logic [31:0] K = 32'h3c3c3c3c; // untouched memory pattern
	logic mclk, rstn, mrstn, cpuReq, cpuWr, cpuAck, memReq, memWr, memAck;
	logic regWr, regRd, slow, rdPend;
	logic [31:0] cpuAddr, cpuWdata, cpuRdata, memAddr, memWdata, memRdata;
	logic [31:0] regAddr, regWdata, regRdata, lastAddr, seed, d1, d2, d4;
	int nRd, nWr, n_errors, checked;
	logic [31:0] cq[$]; // expected cpu read data
	logic [31:0] rq[$]; // expected register read data
	fwc_cache i_fwc_cache (.mclk(mclk), .rstn(rstn), .mrstn(mrstn), .cpuReq(cpuReq),
		.cpuWr(cpuWr), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuAck(cpuAck),
		.cpuRdata(cpuRdata), .memReq(memReq), .memWr(memWr), .memAddr(memAddr),
		.memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
	fwc_mem_model i_fwc_mem_model (.mclk(mclk), .rstn(rstn), .slow(slow),
		.memReq(memReq), .memWr(memWr), .memAddr(memAddr), .memWdata(memWdata),
		.memAck(memAck), .memRdata(memRdata), .lastAddr(lastAddr), .nRd(nRd), .nWr(nWr));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// xorshift source for write data and memory speed
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic tally_and_finish();
		if (n_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic regW(input logic [31:0] d);
		@(posedge mclk);
		regAddr <= CR;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : regW
	task automatic regR(input logic [31:0] a, input logic [31:0] e);
		@(posedge mclk);
		rq.push_back(e);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
	endtask : regR
	// one cpu access, then wait for the expected external word counts
	task automatic op(input logic [31:0] a, input logic w, input logic [31:0] d,
			input logic [31:0] e, input int dr, input int dw);
		int r0;
		int w0;
		int n;
		r0 = nRd;
		w0 = nWr;
		n = 0;
		@(posedge mclk);
		cq.push_back(w ? 32'h0 : e);
		void'(rnd());
		slow <= seed[3];
		cpuReq <= 1'b1;
		cpuWr <= w;
		cpuAddr <= a;
		cpuWdata <= d;
		do @(posedge mclk); while (cpuAck !== 1'b1 && ++n < 3000);
		cpuReq <= 1'b0;
		while ((nRd - r0 != dr || nWr - w0 != dw) && ++n < 3000) @(posedge mclk);
		if (n >= 3000) n_errors++;
		chk("external reads", nRd - r0, dr);
		chk("external writes", nWr - w0, dw);
	endtask : op
	// results are compared when the design answers, oldest note first
	always @(posedge mclk) begin
		if (rdPend === 1'b1) chk("regRdata", regRdata, rq.pop_front());
		rdPend <= regRd;
		if (cpuAck === 1'b1) chk("cpuRdata", cpuRdata, cq.pop_front());
	end
	// hang guard
	initial begin
		repeat (40000) @(posedge mclk);
		n_errors++;
		tally_and_finish();
	end
	initial begin
		{cpuReq, cpuWr, regWr, regRd, slow, mrstn, rstn} = 7'h02;
		{cpuAddr, cpuWdata, regAddr, regWdata} = '0;
		seed = 32'h8ffc;
		n_errors = 0;
		checked = 0;
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		regR(CR, 32'h0);
		regR(32'hffffffe8, 32'h0);
		regW(32'h8);
		regW(32'h1);
		regR(CR, 32'h1);
		op(32'h80000148, 0, 0, 32'h148 ^ K, 4, 0);
		chk("fill address", lastAddr, 32'h0000014c);
		op(32'h00000144, 0, 0, 32'h144 ^ K, 0, 0);
		d1 = rnd();
		op(32'h140, 1, d1, 0, 0, 0);
		op(32'h140, 0, 0, d1, 0, 0);
		for (int i = 1; i < 4; i++) op(32'h140 + 32'h800 * i, 0, 0, (32'h140 + 32'h800 * i) ^ K, 4, 0);
		op(32'h2140, 0, 0, 32'h2140 ^ K, 4, 4);
		op(32'h940, 0, 0, 32'h940 ^ K, 0, 0);
		op(32'ha0000140, 0, 0, d1, 1, 0);
		regW(32'h3);
		d2 = rnd();
		op(32'h940, 1, d2, 0, 0, 1);
		op(32'h80000940, 0, 0, d2, 0, 0);
		op(32'h3140, 1, d2, 0, 0, 1);
		op(32'h3140, 0, 0, d2, 4, 0);
		regW(32'h5);
		d4 = rnd();
		op(32'h80004140, 1, d4, 0, 4, 0);
		op(32'h4140, 0, 0, d4, 0, 0);
		regW(32'h0);
		op(32'h4140, 0, 0, 32'h4140 ^ K, 1, 0);
		mrstn <= 1'b0;
		repeat (2) @(posedge mclk);
		mrstn <= 1'b1;
		regR(CR, 32'h0);
		regW(32'h5);
		op(32'h4140, 0, 0, d4, 0, 0);
		regW(32'h9);
		op(32'h4140, 0, 0, 32'h4140 ^ K, 4, 0);
		repeat (4) @(posedge mclk);
		tally_and_finish();
	end
endmodule : test_fwc_cache

// *** hw/fwc_cache.sv ***
// four-way unified cache controller with write-back buffer and control register
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
module fwc_cache #(
	parameter int WAYS = fwc_pkg::WAYS,
	parameter int ENTRIES = fwc_pkg::ENTRIES
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic mrstn,
	input wire logic cpuReq,
	input wire logic cpuWr,
	input wire logic [31:0] cpuAddr,
	input wire logic [31:0] cpuWdata,
	output logic cpuAck,
	output logic [31:0] cpuRdata,
	output logic memReq,
	output logic memWr,
	output logic [31:0] memAddr,
	output logic [31:0] memWdata,
	input wire logic memAck,
	input wire logic [31:0] memRdata,
	input wire logic [31:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata
);
	fwc_pkg::fwc_state_t state_q; // controller state
	logic anyReset; // power-on or manual reset
	logic ctrlEn_q; // cache enable
	logic ctrlWt_q; // write_thru_select
	logic ctrlCb_q; // copyback_select
	logic regHit; // register port addresses cache_control
	logic flushPulse; // flush_all written as one
	logic [31:0] regRdata_q; // read data, valid the cycle after the strobe
	logic [31:0] reqAddr_q; // captured cpu address
	logic reqWr_q; // captured direction
	logic [31:0] reqData_q; // captured write data
	logic [6:0] idx; // entry index
	logic [1:0] word; // word within line
	logic [21:0] reqTag; // tag with shadow bits masked
	logic [3:0] valid_q [ENTRIES]; // valid flag per way
	logic [3:0] dirty_q [ENTRIES]; // dirty flag per way
	logic [5:0] lru_q [ENTRIES]; // recency bits per index
	logic [21:0] tagRd [WAYS]; // tag read data per way
	logic [31:0] dataRd [WAYS]; // data read data per way
	logic [3:0] tWe; // tag write enables
	logic [3:0] dWe; // data write enables
	logic [6:0] tAddr; // tag array address
	logic [8:0] dAddr; // data array address
	logic [31:0] dWdata; // data array write data
	logic [3:0] hitVec; // per way match
	logic hit; // any way matches
	logic [1:0] hitWay; // matching way
	logic cacheable; // enabled and cacheable region
	logic wbm; // write-back mode for this access
	logic [1:0] victim; // way chosen for replacement
	logic needEvict; // victim holds dirty data in write-back mode
	logic wbClash; // buffered line is the requested line
	logic doHit; // hit taken this cycle
	logic [1:0] victim_q; // victim captured at lookup
	logic [21:0] victimTag_q; // victim tag captured at lookup
	logic [2:0] evCnt_q; // eviction read step
	logic [1:0] evPrev; // word captured this eviction step
	logic [1:0] fillCnt_q; // fill word counter
	logic mainDone; // controller bus transfer finished
	logic wbDone; // buffer bus transfer finished
	logic fillDone; // last fill word arrived
	logic cpuAck_q; // cpu answer pulse
	logic [31:0] cpuRdata_q; // cpu read data
	logic memReq_q; // external request held until ack
	logic memWr_q; // external direction
	logic [31:0] memAddr_q; // external address
	logic [31:0] memWdata_q; // external write data
	logic memOwnWb_q; // current transfer belongs to the buffer
	logic wbPend_q; // write-back buffer holds a line
	logic [1:0] wbCnt_q; // next buffered word to write
	logic [27:0] bufferPhysAddr_q; // buffered line address 31..4
	logic [31:0] wbData_q [4]; // buffered line words

	assign anyReset = !rstn || !mrstn;
	assign idx = reqAddr_q[10:4];
	assign word = reqAddr_q[3:2];
	assign reqTag = {3'h0, reqAddr_q[28:10]};
	assign regHit = (regAddr == fwc_pkg::CTRL_OFFSET);
	assign flushPulse = regWr && regHit && regWdata[fwc_pkg::CTRL_FLUSH_BIT];
	assign evPrev = 2'(evCnt_q - 3'h1);
	assign mainDone = memReq_q && memAck && !memOwnWb_q;
	assign wbDone = memReq_q && memAck && memOwnWb_q;
	assign fillDone = (state_q == fwc_pkg::ST_FILL) && mainDone && (fillCnt_q == 2'h3);

	// tag and data arrays, one pair per way; neither is cleared by any reset
	for (genvar w = 0; w < WAYS; w++) begin : g_way
		fwc_ram #(.WIDTH(fwc_pkg::TAG_W), .DEPTH(ENTRIES), .AW(7)) uTag (
			.mclk(mclk),
			.we(tWe[w]),
			.addr(tAddr),
			.wdata(reqTag),
			.rdata(tagRd[w])
		);
		fwc_ram #(.WIDTH(32), .DEPTH(ENTRIES * fwc_pkg::WORDS), .AW(9)) uData (
			.mclk(mclk),
			.we(dWe[w]),
			.addr(dAddr),
			.wdata(dWdata),
			.rdata(dataRd[w])
		);
	end

	// lookup: compare all four tags, a hit also needs the valid flag
	always_comb begin
		hitWay = 2'h0;
		for (int w = 0; w < WAYS; w++) begin
			hitVec[w] = valid_q[idx][w] && (tagRd[w] == reqTag);
			if (hitVec[w]) begin
				hitWay = w[1:0];
			end
		end
		hit = |hitVec;
	end

	// region, mode and replacement decisions for the captured request
	assign cacheable = ctrlEn_q && fwc_pkg::regionCached(reqAddr_q[31:29]);
	assign wbm = fwc_pkg::writeBackMode(reqAddr_q[31:29], ctrlWt_q, ctrlCb_q);
	assign victim = fwc_pkg::lruVictim(lru_q[idx]);
	assign needEvict = valid_q[idx][victim] && dirty_q[idx][victim] && wbm;
	// a miss to the buffered line must wait, memory still holds stale data
	assign wbClash = wbPend_q && (bufferPhysAddr_q == {3'h0, reqAddr_q[28:4]});
	assign doHit = (state_q == fwc_pkg::ST_LOOK) && cacheable && hit;

	// array addressing: in idle the arrays look up the incoming address directly
	always_comb begin
		tAddr = idx;
		dAddr = {idx, word};
		tWe = 4'h0;
		dWe = 4'h0;
		dWdata = reqData_q;
		case (state_q)
			fwc_pkg::ST_IDLE: begin
				tAddr = cpuAddr[10:4];
				dAddr = {cpuAddr[10:4], cpuAddr[3:2]};
			end
			fwc_pkg::ST_LOOK: begin
				if (doHit && reqWr_q) begin
					dWe[hitWay] = 1'b1;
				end
			end
			fwc_pkg::ST_EVICT: begin
				dAddr = {idx, evCnt_q[1:0]};
			end
			fwc_pkg::ST_FILL: begin
				dAddr = {idx, fillCnt_q};
				dWe[victim_q] = mainDone;
				// write miss: the cpu word replaces the fetched one
				if (!(reqWr_q && fillCnt_q == word)) begin
					dWdata = memRdata;
				end
				tWe[victim_q] = fillDone;
			end
			default: begin
			end
		endcase
	end

	// control register: enable and mode bits; bits 4 and 5 are not stored
	always_ff @(posedge mclk) begin
		if (anyReset) begin
			ctrlEn_q <= fwc_pkg::CTRL_RESET[fwc_pkg::CTRL_ENABLE_BIT];
			ctrlWt_q <= fwc_pkg::CTRL_RESET[fwc_pkg::CTRL_WT_BIT];
			ctrlCb_q <= fwc_pkg::CTRL_RESET[fwc_pkg::CTRL_CB_BIT];
		end else if (regWr && regHit) begin
			ctrlEn_q <= regWdata[fwc_pkg::CTRL_ENABLE_BIT];
			ctrlWt_q <= regWdata[fwc_pkg::CTRL_WT_BIT];
			ctrlCb_q <= regWdata[fwc_pkg::CTRL_CB_BIT];
		end
	end

	// register read: answer next cycle, unmapped addresses read zero
	always_ff @(posedge mclk) begin
		if (anyReset) begin
			regRdata_q <= 32'h00000000;
		end else if (regRd && regHit) begin
			regRdata_q <= {29'h0, ctrlCb_q, ctrlWt_q, ctrlEn_q};
		end else begin
			regRdata_q <= 32'h00000000;
		end
	end

	// request capture when idle; the acknowledge cycle is skipped so a held request
	// is not taken twice
	always_ff @(posedge mclk) begin
		if (anyReset) begin
			reqAddr_q <= 32'h00000000;
			reqWr_q <= 1'b0;
			reqData_q <= 32'h00000000;
		end else if (state_q == fwc_pkg::ST_IDLE && cpuReq && !cpuAck_q) begin
			reqAddr_q <= cpuAddr;
			reqWr_q <= cpuWr;
			reqData_q <= cpuWdata;
		end
	end

	// controller sequence
	always_ff @(posedge mclk) begin
		if (anyReset) begin
			state_q <= fwc_pkg::ST_IDLE;
		end else begin
			case (state_q)
				fwc_pkg::ST_IDLE: begin
					if (cpuReq && !cpuAck_q) begin
						state_q <= fwc_pkg::ST_LOOK;
					end
				end
				fwc_pkg::ST_LOOK: begin
					if (!cacheable) begin
						state_q <= wbClash ? fwc_pkg::ST_WAIT : fwc_pkg::ST_EXT;
					end else if (hit) begin
						state_q <= (reqWr_q && !wbm) ? fwc_pkg::ST_EXT : fwc_pkg::ST_IDLE;
					end else if (reqWr_q && !wbm) begin
						state_q <= wbClash ? fwc_pkg::ST_WAIT : fwc_pkg::ST_EXT;
					end else if (wbClash || (needEvict && wbPend_q)) begin
						state_q <= fwc_pkg::ST_WAIT;
					end else if (needEvict) begin
						state_q <= fwc_pkg::ST_EVICT;
					end else begin
						state_q <= fwc_pkg::ST_FILL;
					end
				end
				fwc_pkg::ST_WAIT: begin
					// arrays still present the same index, so lookup is simply rerun
					if (!wbPend_q) begin
						state_q <= fwc_pkg::ST_LOOK;
					end
				end
				fwc_pkg::ST_EVICT: begin
					if (evCnt_q == 3'h4) begin
						state_q <= fwc_pkg::ST_FILL;
					end
				end
				fwc_pkg::ST_FILL: begin
					if (fillDone) begin
						state_q <= fwc_pkg::ST_IDLE;
					end
				end
				fwc_pkg::ST_EXT: begin
					if (mainDone) begin
						state_q <= fwc_pkg::ST_IDLE;
					end
				end
				default: begin
					state_q <= fwc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// victim capture and step counters
	always_ff @(posedge mclk) begin
		if (anyReset) begin
			victim_q <= 2'h0;
			victimTag_q <= 22'h000000;
			evCnt_q <= 3'h0;
			fillCnt_q <= 2'h0;
		end else if (state_q == fwc_pkg::ST_LOOK) begin
			victim_q <= victim;
			victimTag_q <= tagRd[victim];
			evCnt_q <= 3'h0;
			fillCnt_q <= 2'h0;
		end else begin
			if (state_q == fwc_pkg::ST_EVICT) begin
				evCnt_q <= 3'(evCnt_q + 3'h1);
			end
			if (state_q == fwc_pkg::ST_FILL && mainDone) begin
				fillCnt_q <= 2'(fillCnt_q + 2'h1);
			end
		end
	end

	// valid flags: only power-on reset and flush clear them; a fill landing in the
	// flush cycle still sets its flag
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			for (int i = 0; i < ENTRIES; i++) begin
				valid_q[i] <= 4'h0;
			end
		end else begin
			if (flushPulse) begin
				for (int i = 0; i < ENTRIES; i++) begin
					valid_q[i] <= 4'h0;
				end
			end
			if (fillDone) begin
				valid_q[idx][victim_q] <= 1'b1;
			end
		end
	end

	// dirty flags: set by write-back writes, cleared by a clean fill
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			for (int i = 0; i < ENTRIES; i++) begin
				dirty_q[i] <= 4'h0;
			end
		end else begin
			if (flushPulse) begin
				for (int i = 0; i < ENTRIES; i++) begin
					dirty_q[i] <= 4'h0;
				end
			end
			if (doHit && reqWr_q && wbm) begin
				dirty_q[idx][hitWay] <= 1'b1;
			end
			if (fillDone) begin
				dirty_q[idx][victim_q] <= reqWr_q;
			end
		end
	end

	// recency bits: survive manual reset, updated on every hit and on each fill
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			for (int i = 0; i < ENTRIES; i++) begin
				lru_q[i] <= fwc_pkg::LRU_RESET;
			end
		end else if (doHit) begin
			lru_q[idx] <= fwc_pkg::lruTouch(lru_q[idx], hitWay);
		end else if (fillDone) begin
			lru_q[idx] <= fwc_pkg::lruTouch(lru_q[idx], victim_q);
		end
	end

	// cpu answer: one-cycle pulse with data for reads
	always_ff @(posedge mclk) begin
		if (anyReset) begin
			cpuAck_q <= 1'b0;
			cpuRdata_q <= 32'h00000000;
		end else begin
			cpuAck_q <= 1'b0;
			if (doHit && (!reqWr_q || wbm)) begin
				cpuAck_q <= 1'b1;
				cpuRdata_q <= reqWr_q ? 32'h00000000 : dataRd[hitWay];
			end
			if (state_q == fwc_pkg::ST_FILL && mainDone && !reqWr_q && fillCnt_q == word) begin
				cpuAck_q <= 1'b1;
				cpuRdata_q <= memRdata;
			end
			if (fillDone && reqWr_q) begin
				cpuAck_q <= 1'b1;
				cpuRdata_q <= 32'h00000000; // writes answer with zero data
			end
			if (state_q == fwc_pkg::ST_EXT && mainDone) begin
				cpuAck_q <= 1'b1;
				cpuRdata_q <= reqWr_q ? 32'h00000000 : memRdata;
			end
		end
	end

	// write-back buffer: loaded from the victim, drained word by word when the bus is free
	always_ff @(posedge mclk) begin
		if (anyReset) begin
			wbPend_q <= 1'b0;
			wbCnt_q <= 2'h0;
			bufferPhysAddr_q <= 28'h0000000;
		end else begin
			if (state_q == fwc_pkg::ST_EVICT && evCnt_q != 3'h0) begin
				wbData_q[evPrev] <= dataRd[victim_q];
			end
			if (state_q == fwc_pkg::ST_EVICT && evCnt_q == 3'h4) begin
				// address latched only as the line enters, so hits during a drain keep it
				bufferPhysAddr_q <= {victimTag_q, idx[5:0]};
				wbPend_q <= 1'b1;
				wbCnt_q <= 2'h0;
			end else if (wbDone) begin
				wbCnt_q <= 2'(wbCnt_q + 2'h1);
				if (wbCnt_q == 2'h3) begin
					wbPend_q <= 1'b0;
				end
			end
		end
	end

	// external bus: fill and direct accesses go first, the buffer only uses idle slots
	always_ff @(posedge mclk) begin
		if (anyReset) begin
			memReq_q <= 1'b0;
			memWr_q <= 1'b0;
			memAddr_q <= 32'h00000000;
			memWdata_q <= 32'h00000000;
			memOwnWb_q <= 1'b0;
		end else if (memReq_q) begin
			if (memAck) begin
				memReq_q <= 1'b0;
			end
		end else if (state_q == fwc_pkg::ST_FILL) begin
			memReq_q <= 1'b1;
			memOwnWb_q <= 1'b0;
			memWr_q <= 1'b0;
			memAddr_q <= {3'h0, reqAddr_q[28:4], fillCnt_q, 2'h0};
		end else if (state_q == fwc_pkg::ST_EXT) begin
			memReq_q <= 1'b1;
			memOwnWb_q <= 1'b0;
			memWr_q <= reqWr_q;
			memAddr_q <= reqAddr_q;
			memWdata_q <= reqData_q;
		end else if (wbPend_q) begin
			memReq_q <= 1'b1;
			memOwnWb_q <= 1'b1;
			memWr_q <= 1'b1;
			memAddr_q <= {bufferPhysAddr_q, wbCnt_q, 2'h0};
			memWdata_q <= wbData_q[wbCnt_q];
		end
	end

	assign cpuAck = cpuAck_q;
	assign cpuRdata = cpuRdata_q;
	assign memReq = memReq_q;
	assign memWr = memWr_q;
	assign memAddr = memAddr_q;
	assign memWdata = memWdata_q;
	assign regRdata = regRdata_q;
endmodule : fwc_cache

// *** hw/fwc_pkg.sv ***
// constants, types and helper functions shared by the four-way cache
package fwc_pkg;
	localparam int WAYS = 4; // associativity
	localparam int ENTRIES = 128; // lines per way
	localparam int WORDS = 4; // 32-bit words per line
	localparam int TAG_W = 22; // tag holds address bits 28..10, top three bits zero
	localparam int LRU_W = 6; // recency bits per index
	localparam logic [31:0] CTRL_OFFSET = 32'hffffffec; // cache_control address
	localparam logic [31:0] CTRL_RESET = 32'h00000000; // cache_control reset value
	localparam int CTRL_ENABLE_BIT = 0; // cache enable
	localparam int CTRL_WT_BIT = 1; // write_thru_select
	localparam int CTRL_CB_BIT = 2; // copyback_select
	localparam int CTRL_FLUSH_BIT = 3; // flush_all, reads as zero
	localparam logic [5:0] LRU_RESET = 6'h00; // recency value after power-on
	localparam logic [2:0] REGION_KERNEL_CACHED = 3'h4; // cached, copyback_select governs
	localparam logic [2:0] REGION_UNCACHED = 3'h5; // never cached
	localparam logic [2:0] REGION_IO = 3'h7; // i/o area, never cached

	// one-hot controller states
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_LOOK = 6'h02,
		ST_WAIT = 6'h04,
		ST_EVICT = 6'h08,
		ST_FILL = 6'h10,
		ST_EXT = 6'h20
	} fwc_state_t;

	// region decode: only the two uncached patterns bypass
	function automatic logic regionCached(input logic [2:0] r);
		regionCached = (r != REGION_UNCACHED) && (r != REGION_IO);
	endfunction : regionCached

	// write mode: kernel region follows copyback_select, others follow write_thru_select
	function automatic logic writeBackMode(input logic [2:0] r, input logic wt, input logic cb);
		if (r == REGION_KERNEL_CACHED) begin
			writeBackMode = cb;
		end else begin
			writeBackMode = !wt;
		end
	endfunction : writeBackMode

	// bit5:(0,1) bit4:(0,2) bit3:(0,3) bit2:(1,2) bit1:(1,3) bit0:(2,3); 1 = lower way older
	function automatic logic [1:0] lruVictim(input logic [5:0] l);
		if (l[5] && l[4] && l[3]) begin
			lruVictim = 2'h0;
		end else if (!l[5] && l[2] && l[1]) begin
			lruVictim = 2'h1;
		end else if (!l[4] && !l[2] && l[0]) begin
			lruVictim = 2'h2;
		end else begin
			lruVictim = 2'h3;
		end
	endfunction : lruVictim

	// mark way w most recently used, keeping the other pair orders
	function automatic logic [5:0] lruTouch(input logic [5:0] l, input logic [1:0] w);
		lruTouch = l;
		case (w)
			2'h0: begin
				lruTouch[5] = 1'b0; lruTouch[4] = 1'b0; lruTouch[3] = 1'b0;
			end
			2'h1: begin
				lruTouch[5] = 1'b1; lruTouch[2] = 1'b0; lruTouch[1] = 1'b0;
			end
			2'h2: begin
				lruTouch[4] = 1'b1; lruTouch[2] = 1'b1; lruTouch[0] = 1'b0;
			end
			default: begin
				lruTouch[3] = 1'b1; lruTouch[1] = 1'b1; lruTouch[0] = 1'b1;
			end
		endcase
	endfunction : lruTouch
endpackage : fwc_pkg

// *** hw/fwc_ram.sv ***
// single-port synchronous memory with registered read data
`timescale 1ns/10ps
module fwc_ram #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 512,
	parameter int AW = 9
) (
	input wire logic mclk,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH]; // contents are not reset, like a real array

	// write when enabled, read the addressed word every cycle
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule : fwc_ram
